// File: adc_hpf_route_pkg.sv
// Shared constants, register map and carrier types for the ADC high-pass and routing block.
package adc_hpf_route_pkg;

  // Sample format of each ADC channel.
  localparam int SAMPLE_W = 24;
  typedef logic signed [SAMPLE_W-1:0] sample_t;
  localparam sample_t SAMPLE_MAX = 24'h7FFFFF;
  localparam sample_t SAMPLE_MIN = 24'h800000;

  // One stereo sample pair travels as a single word.
  typedef struct packed {
    sample_t left;
    sample_t right;
  } stereo_t;

  // Wishbone geometry; registers sit at byte address = index * 4.
  localparam int WB_ADR_W  = 8;
  localparam int WB_DAT_W  = 32;
  localparam int WB_SEL_W  = 4;
  localparam int IDX_W     = 6;
  localparam int IDX_LSB   = 2;
  localparam logic [IDX_W-1:0] SLOT_SRC_IDX = 6'h04;
  localparam logic [IDX_W-1:0] FILT_POL_IDX = 6'h0E;
  localparam logic [IDX_W-1:0] STATUS_IDX   = 6'h10;

  // Slot source control fields.
  localparam int LEFT_SRC_BIT  = 15;
  localparam int RIGHT_SRC_BIT = 14;
  localparam logic [15:0] SLOT_SRC_RST  = 16'h4000;
  localparam logic [15:0] SLOT_SRC_MASK = 16'hC000;

  // Filter and polarity control fields.
  localparam int HPF_EN_BIT = 8;
  localparam int CUT_MSB    = 6;
  localparam int CUT_LSB    = 5;
  localparam int INV_L_BIT  = 1;
  localparam int INV_R_BIT  = 0;
  localparam logic [15:0] FILT_POL_RST  = 16'h0100;
  localparam logic [15:0] FILT_POL_MASK = 16'h0163;

  // Status fields.
  localparam int SAT_BIT       = 0;
  localparam int OUT_VALID_BIT = 1;
  localparam int STG_BIT       = 2;
  localparam int IN_READY_BIT  = 3;
  localparam int LEVEL_LSB     = 8;

  // Cut-off codes.
  typedef enum logic [1:0] {CUT_HIFI, CUT_VOICE1, CUT_VOICE2, CUT_VOICE3} cutoff_t;

  // Pole coefficients as unsigned fractions of 2^COEF_FRAC, fixed per code so fc tracks fs.
  localparam int COEF_FRAC = 16;
  localparam logic [15:0] COEF_HIFI   = 16'hFFDD;
  localparam logic [15:0] COEF_VOICE1 = 16'hF33C;
  localparam logic [15:0] COEF_VOICE2 = 16'hE5DD;
  localparam logic [15:0] COEF_VOICE3 = 16'hCA51;

  // Output buffer size.
  localparam int FIFO_DEPTH = 8;
  localparam int LEVEL_W    = 4;

endpackage

// File: sample_fifo.sv
// Shift-register FIFO whose head word and flags are registers.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  // Clock and reset.
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  // Filling side.
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Draining side.
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i,
  // Fill level.
  output logic [CNT_W-1:0]      level_o
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CNT_W-1:0]            count;
    logic                        full;
    logic                        empty;
  } fifo_state_t;

  fifo_state_t state_reg;
  fifo_state_t state_next;

  // The head always sits in entry zero, so the output is a register rather than a read mux.
  always_comb
  begin
    logic [CNT_W-1:0] cnt;
    cnt = state_reg.count;
    state_next = state_reg;
    if (out_ready_i && !state_reg.empty)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        state_next.mem[i] = state_reg.mem[i+1];
      end
      cnt = cnt - 1'b1;
    end
    if (in_valid_i && !state_reg.full)
    begin
      state_next.mem[cnt] = in_data_i;
      cnt = cnt + 1'b1;
    end
    state_next.count = cnt;
    state_next.full  = (cnt == CNT_W'(DEPTH));
    state_next.empty = (cnt == '0);
  end

  // State register.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_reg       <= '0;
      state_reg.empty <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign in_ready_o  = !state_reg.full;
  assign out_valid_o = !state_reg.empty;
  assign out_data_o  = state_reg.mem[0];
  assign level_o     = state_reg.count;

endmodule
`default_nettype wire

// File: adc_hpf_route.sv
// ADC high-pass filter, polarity invert and slot routing with a Wishbone register slave.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RL1] Bit 8 of the filter register turns the high-pass filter on for both channels; off passes samples through.
// [RL2] The filter enable comes out of reset set, so DC removal works with no write.
// [RL3] Bits 6 to 5 pick the cut-off and reset to 00, the hi-fi setting.
// [RL4] The hi-fi setting puts the corner near 3.7 Hz when sampling at 44.1 kHz.
// [RL5] Codes 01, 10 and 11 give about 127 Hz at 16 kHz, 130 Hz at 8 kHz and 267 Hz at 8 kHz.
// [RL6] Each corner is a fixed fraction of the sample rate, so it scales with the rate.
// [RL7] Software should choose a code that keeps a voice corner under 300 Hz at its rate.
// [RL8] Bit 15 of the slot register picks left (0) or right (1) ADC for the left slot, reset 0.
// [RL9] Bit 14 of the slot register picks left (0) or right (1) ADC for the right slot, reset 1.
// [RL10] Bit 1 of the filter register negates the left ADC output, reset 0.
// [RL11] Bit 0 of the filter register negates the right ADC output, reset 0.
// [RL12] Negation is two's complement and the most negative code becomes the largest positive one.
// [RL13] Each channel is filtered, then inverted, then routed, so both slots may carry one ADC.
module adc_hpf_route
  import adc_hpf_route_pkg::*;
(
  // Clock and reset.
  input  wire logic                core_clk_i,
  input  wire logic                srst_i,
  // Wishbone classic slave.
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [WB_SEL_W-1:0] wb_sel_i,
  input  wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic      [WB_DAT_W-1:0] wb_dat_o,
  output logic                     wb_ack_o,
  // ADC sample stream in.
  input  wire logic                adc_valid_i,
  input  wire stereo_t             adc_data_i,
  output logic                     adc_ready_o,
  // Audio interface slot stream out.
  output logic                     slot_valid_o,
  output stereo_t                  slot_data_o,
  input  wire logic                slot_ready_i
);

  typedef struct packed {
    logic [15:0]         slot_ctl;
    logic [15:0]         filt_ctl;
    logic                ack;
    logic [WB_DAT_W-1:0] rdata;
    logic                sat_seen;
    logic                in_ready;
    logic                stg_valid;
    stereo_t             stg;
    stereo_t             x_prev;
    stereo_t             y_prev;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [LEVEL_W-1:0] fifo_level;
  logic               push;
  stereo_t            push_data;
  stereo_t            filt_out;
  stereo_t            proc_out;
  logic               sat_l;
  logic               sat_r;

  // Clip a widened result back to the sample range.
  function automatic sample_t clip(input logic signed [26:0] v);
    if (v > 27'(SAMPLE_MAX))
    begin
      return SAMPLE_MAX;
    end
    else if (v < 27'(SAMPLE_MIN))
    begin
      return SAMPLE_MIN;
    end
    return v[SAMPLE_W-1:0];
  endfunction

  // One step of y = a * (y' + x - x'), a first-order DC blocker.
  function automatic sample_t hpf_step(
    input sample_t     x,
    input sample_t     xp,
    input sample_t     yp,
    input logic [15:0] coef
  );
    logic signed [25:0] acc;
    logic signed [42:0] prod;
    acc  = 26'(yp) + 26'(x) - 26'(xp);
    prod = acc * $signed({1'b0, coef});
    return clip(27'(prod >>> COEF_FRAC));
  endfunction

  // Saturating two's-complement negation; the lone code with no positive twin clips.
  function automatic sample_t neg_sat(input sample_t x);
    if (x == SAMPLE_MIN)
    begin
      return SAMPLE_MAX; // RL12
    end
    return -x; // RL12
  endfunction

  // Pole fraction for the selected code; fixed per code, so the corner tracks fs.
  function automatic logic [15:0] coef_of(input logic [1:0] code);
    case (cutoff_t'(code))
      CUT_HIFI:   return COEF_HIFI;   // RL4 RL6
      CUT_VOICE1: return COEF_VOICE1; // RL5 RL6
      CUT_VOICE2: return COEF_VOICE2; // RL5 RL6
      CUT_VOICE3: return COEF_VOICE3; // RL5 RL6
      default:    return COEF_HIFI;
    endcase
  endfunction

  // Datapath: filter, then invert, then route.
  always_comb
  begin
    logic [15:0] coef;
    coef = coef_of(state_reg.filt_ctl[CUT_MSB:CUT_LSB]); // RL3
    if (state_reg.filt_ctl[HPF_EN_BIT]) // RL1
    begin
      filt_out.left  = hpf_step(state_reg.stg.left, state_reg.x_prev.left,
                                state_reg.y_prev.left, coef);
      filt_out.right = hpf_step(state_reg.stg.right, state_reg.x_prev.right,
                                state_reg.y_prev.right, coef);
    end
    else
    begin
      filt_out = state_reg.stg; // RL1
    end
    sat_l = state_reg.filt_ctl[INV_L_BIT] && (filt_out.left == SAMPLE_MIN);
    sat_r = state_reg.filt_ctl[INV_R_BIT] && (filt_out.right == SAMPLE_MIN);
    proc_out.left  = state_reg.filt_ctl[INV_L_BIT] ? neg_sat(filt_out.left)
                                                   : filt_out.left;  // RL10 RL13
    proc_out.right = state_reg.filt_ctl[INV_R_BIT] ? neg_sat(filt_out.right)
                                                   : filt_out.right; // RL11 RL13
    push_data.left  = state_reg.slot_ctl[LEFT_SRC_BIT] ? proc_out.right
                                                       : proc_out.left;  // RL8 RL13
    push_data.right = state_reg.slot_ctl[RIGHT_SRC_BIT] ? proc_out.right
                                                        : proc_out.left; // RL9 RL13
    push = state_reg.stg_valid && fifo_in_ready;
  end

  // Next state: bus slave, control registers and the one-sample holding stage.
  always_comb
  begin
    logic                req;
    logic [IDX_W-1:0]    idx;
    logic [WB_DAT_W-1:0] rd;
    req = wb_cyc_i && wb_stb_i;
    idx = wb_adr_i[IDX_LSB +: IDX_W];
    rd  = '0;
    state_next = state_reg;

    // Acknowledge one cycle after the request; ack is dropped the cycle after it was given.
    state_next.ack = req && !state_reg.ack;
    case (idx)
      SLOT_SRC_IDX: rd = WB_DAT_W'(state_reg.slot_ctl);
      FILT_POL_IDX: rd = WB_DAT_W'(state_reg.filt_ctl);
      STATUS_IDX:
      begin
        rd[SAT_BIT]                       = state_reg.sat_seen;
        rd[OUT_VALID_BIT]                 = fifo_out_valid;
        rd[STG_BIT]                       = state_reg.stg_valid;
        rd[IN_READY_BIT]                  = state_reg.in_ready;
        rd[LEVEL_LSB +: LEVEL_W]          = fifo_level;
      end
      default:      rd = '0;
    endcase
    if (state_next.ack)
    begin
      state_next.rdata = rd;
    end

    // Writes land on the edge where the master sees ack, honouring byte selects.
    if (req && wb_we_i && state_reg.ack)
    begin
      case (idx)
        SLOT_SRC_IDX:
        begin
          if (wb_sel_i[0])
          begin
            state_next.slot_ctl[7:0] = wb_dat_i[7:0] & SLOT_SRC_MASK[7:0];
          end
          if (wb_sel_i[1])
          begin
            state_next.slot_ctl[15:8] = wb_dat_i[15:8] & SLOT_SRC_MASK[15:8]; // RL8 RL9
          end
        end
        FILT_POL_IDX:
        begin
          if (wb_sel_i[0])
          begin
            state_next.filt_ctl[7:0] = wb_dat_i[7:0] & FILT_POL_MASK[7:0]; // RL3 RL10 RL11
          end
          if (wb_sel_i[1])
          begin
            state_next.filt_ctl[15:8] = wb_dat_i[15:8] & FILT_POL_MASK[15:8]; // RL1
          end
        end
        STATUS_IDX:
        begin
          if (wb_sel_i[0] && wb_dat_i[SAT_BIT])
          begin
            state_next.sat_seen = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // A clipping event in the same cycle as the clear keeps the flag set.
    if (push && (sat_l || sat_r))
    begin
      state_next.sat_seen = 1'b1;
    end

    // Filter history advances only when a sample really leaves the stage.
    if (push)
    begin
      state_next.stg_valid = 1'b0;
      state_next.x_prev    = state_reg.stg;
      state_next.y_prev    = state_reg.filt_ctl[HPF_EN_BIT] ? filt_out : '0;
    end
    if (state_reg.in_ready && adc_valid_i)
    begin
      state_next.stg       = adc_data_i;
      state_next.stg_valid = 1'b1;
    end
    // Ready is a register, so a stage refill costs one cycle; ample at audio rates.
    state_next.in_ready = !state_next.stg_valid;
  end

  // State register; the reset values give filter on, hi-fi, no invert, straight routing.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_reg          <= '0;
      state_reg.slot_ctl <= SLOT_SRC_RST; // RL8 RL9
      state_reg.filt_ctl <= FILT_POL_RST; // RL2 RL3 RL10 RL11
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // The output buffer stalls the stage when the interface stops draining.
  sample_fifo #(
    .WIDTH ($bits(stereo_t)),
    .DEPTH (FIFO_DEPTH),
    .CNT_W (LEVEL_W)
  ) u_out_fifo (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (push),
    .in_data_i   (push_data),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (slot_data_o),
    .out_ready_i (slot_ready_i),
    .level_o     (fifo_level)
  );

  assign wb_dat_o     = state_reg.rdata;
  assign wb_ack_o     = state_reg.ack;
  assign adc_ready_o  = state_reg.in_ready;
  assign slot_valid_o = fifo_out_valid;

  // Checks on the design's own behaviour.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ack_pulse;
    ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_filter_reset: assert property ($past(srst_i) |-> // RL2 RL3
    state_reg.filt_ctl[HPF_EN_BIT] &&
    cutoff_t'(state_reg.filt_ctl[CUT_MSB:CUT_LSB]) == CUT_HIFI)
    else $error("filter control not at reset value after reset");

  chk_slot_reset: assert property ($past(srst_i) |-> // RL8 RL9
    !state_reg.slot_ctl[LEFT_SRC_BIT] && state_reg.slot_ctl[RIGHT_SRC_BIT])
    else $error("slot sources not at reset value after reset");

  chk_bypass_pass: assert property (push && !state_reg.filt_ctl[HPF_EN_BIT] && // RL1
    !state_reg.filt_ctl[INV_L_BIT] |-> proc_out.left == state_reg.stg.left)
    else $error("disabled filter altered the left sample");

  chk_bypass_right: assert property (push && !state_reg.filt_ctl[HPF_EN_BIT] && // RL1
    !state_reg.filt_ctl[INV_R_BIT] |-> proc_out.right == state_reg.stg.right)
    else $error("disabled filter altered the right sample");

  chk_dc_removed: assert property (push && state_reg.filt_ctl[HPF_EN_BIT] && // RL1
    state_reg.stg.left == state_reg.x_prev.left && state_reg.y_prev.left == '0
    |-> filt_out.left == '0)
    else $error("filter passed a constant input");

  // The left route and right bypass checks are held against the raw stage, so a broken selector cannot agree with itself.
  chk_left_route: assert property (push && !state_reg.filt_ctl[HPF_EN_BIT] && // RL8 RL13
    !state_reg.filt_ctl[INV_L_BIT] && !state_reg.filt_ctl[INV_R_BIT] |->
    push_data.left == (state_reg.slot_ctl[LEFT_SRC_BIT] ? state_reg.stg.right
                                                         : state_reg.stg.left))
    else $error("left slot carries the wrong ADC");

  chk_right_route: assert property (push && !state_reg.slot_ctl[RIGHT_SRC_BIT] |-> // RL9
    push_data.right == proc_out.left)
    else $error("right slot did not carry the left ADC");

  chk_right_bypass: assert property (push && !state_reg.filt_ctl[HPF_EN_BIT] && // RL9 RL13
    !state_reg.filt_ctl[INV_L_BIT] && !state_reg.filt_ctl[INV_R_BIT] |->
    push_data.right == (state_reg.slot_ctl[RIGHT_SRC_BIT] ? state_reg.stg.right
                                                           : state_reg.stg.left))
    else $error("right slot carries the wrong ADC");

  chk_invert_left: assert property (push && state_reg.filt_ctl[INV_L_BIT] && // RL10
    filt_out.left != SAMPLE_MIN |-> proc_out.left == -filt_out.left)
    else $error("left inversion wrong");

  chk_invert_rneg: assert property (push && state_reg.filt_ctl[INV_R_BIT] && // RL11
    filt_out.right != SAMPLE_MIN |-> proc_out.right == -filt_out.right)
    else $error("right inversion wrong");

  chk_invert_right: assert property (push && !state_reg.filt_ctl[INV_R_BIT] |-> // RL11
    proc_out.right == filt_out.right)
    else $error("right channel changed without inversion");

  chk_negate_sat: assert property (push && state_reg.filt_ctl[INV_L_BIT] && // RL12
    filt_out.left == SAMPLE_MIN |-> proc_out.left == SAMPLE_MAX ##1 state_reg.sat_seen)
    else $error("most negative code not saturated");

  // Only an acknowledged write or srst_i may clear the saturation flag; nothing else drops it.
  chk_sat_sticky: assert property (state_reg.sat_seen && // RL12
    !(wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) |=> state_reg.sat_seen)
    else $error("saturation flag cleared without a write");

  chk_ready_drop: assert property (adc_valid_i && adc_ready_o |=> !adc_ready_o)
    else $error("input ready stayed high after a take");

  chk_bus_ack: assert property (s_bus_req |-> s_ack_pulse)
    else $error("ack not a single pulse one cycle after request");

endmodule
`default_nettype wire

// File: slot_sink.sv
// Behavioural model of the audio interface serializer that drains the slot stream.
`timescale 1ns/1ps
`default_nettype none
module slot_sink
  import adc_hpf_route_pkg::*;
(
  // Clock and reset.
  input  wire logic    core_clk_i,
  input  wire logic    srst_i,
  // Slot stream from the block.
  input  wire logic    slot_valid_i,
  input  wire stereo_t slot_data_i,
  output logic         slot_ready_o,
  // Pacing from the bench.
  input  wire logic    stall_i,
  input  wire logic    slow_i
);
  stereo_t q[$];
  logic    tick;

  // Take a pair on each accepted edge; slow mode only accepts every other cycle.
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      slot_ready_o <= 1'b0;
      tick         <= 1'b0;
    end
    else
    begin
      if (slot_valid_i && slot_ready_o)
        q.push_back(slot_data_i);
      tick         <= ~tick;
      slot_ready_o <= !stall_i && (!slow_i || tick);
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the ADC high-pass, invert and routing block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adc_hpf_route_pkg::*;
  logic        core_clk_i, srst_i, cyc, stb, we, ack, av, ar, sv, sr, stall, slow;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wd, rdat, rd;
  stereo_t     ad, sd, got;
  logic [15:0] coef [4];
  longint      e1, e2;
  int          failures, checks_done;

  adc_hpf_route i_dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .adc_valid_i(av), .adc_data_i(ad),
    .adc_ready_o(ar), .slot_valid_o(sv), .slot_data_o(sd), .slot_ready_i(sr));
  slot_sink i_sink (.core_clk_i(core_clk_i), .srst_i(srst_i), .slot_valid_i(sv),
    .slot_data_i(sd), .slot_ready_o(sr), .stall_i(stall), .slow_i(slow));

  // Free-running 100 MHz clock.
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang(input string what);
    failures++;
    $display("mismatch %s expected handshake seen timeout", what);
    finish_test();
  endtask

  // One classic Wishbone cycle; read data is kept in rd.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    {cyc, stb, we, adr, wd, sel} <= {1'b1, 1'b1, w, a, d, 4'h3};
    n = 0;
    // The request stands until ack is seen high at a rising edge; data is taken there.
    do
    begin
      @(posedge core_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
      hang("wb_ack");
    rd = rdat;
    {cyc, stb, we, wd} <= {3'b000, ~d};
  endtask

  // Offer one pair and hold it until the block takes it.
  task automatic send(input sample_t l, input sample_t r);
    int n;
    @(posedge core_clk_i);
    av <= 1'b1;
    ad <= {l, r};
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end while (ar !== 1'b1 && n < 50);
    if (ar !== 1'b1)
      hang("adc_ready");
    av <= 1'b0;
    ad <= ~{l, r};
  endtask

  task automatic recv;
    int n;
    n = 0;
    while (i_sink.q.size() == 0 && n < 100)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (i_sink.q.size() == 0)
      hang("slot_valid");
    got = i_sink.q.pop_front();
  endtask

  function automatic logic near(input sample_t s, input longint e);
    longint d;
    d = longint'(s) - e;
    return (d <= 4 && d >= -4);
  endfunction

  // Main sequence.
  initial
  begin
    {srst_i, cyc, stb, we, av, stall, slow} = 7'b1000000;
    {adr, sel, wd, ad} = '0;
    failures = 0;
    checks_done = 0;
    coef = '{COEF_HIFI, COEF_VOICE1, COEF_VOICE2, COEF_VOICE3};
    repeat (10) @(posedge core_clk_i);
    srst_i <= 1'b0;
    wb(1'b0, 8'h10, 32'h0);
    check("slot_reset", rd, 32'h4000);
    wb(1'b0, 8'h38, 32'h0);
    check("filt_reset", rd, 32'h0100);
    wb(1'b1, 8'h38, 32'hFFFF);
    wb(1'b0, 8'h38, 32'h0);
    check("filt_rw", rd, {16'h0, FILT_POL_MASK});
    wb(1'b1, 8'h10, 32'hFFFF);
    wb(1'b0, 8'h10, 32'h0);
    check("slot_rw", rd, 32'hC000);
    wb(1'b1, 8'h20, 32'hFFFF);
    wb(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test registers done");
    // Every source combination with the filter bypassed.
    wb(1'b1, 8'h38, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, 8'h10, {16'h0, i[1:0], 14'h0});
      send(24'h123456, 24'hEDCBA9);
      recv();
      check("route", got, {i[1] ? 24'hEDCBA9 : 24'h123456,
                           i[0] ? 24'hEDCBA9 : 24'h123456});
    end
    $display("test routing done");
    // Inversion, including the saturating corner.
    wb(1'b1, 8'h10, 32'h4000);
    wb(1'b1, 8'h38, 32'h0003);
    send(24'h000010, SAMPLE_MIN);
    recv();
    check("invert_both", got, {24'hFFFFF0, SAMPLE_MAX});
    wb(1'b1, 8'h38, 32'h0002);
    send(SAMPLE_MIN, 24'h000010);
    recv();
    check("invert_left", got, {SAMPLE_MAX, 24'h000010});
    wb(1'b0, 8'h40, 32'h0);
    check("sat_flag", rd[SAT_BIT], 1'b1);
    wb(1'b1, 8'h40, 32'h1);
    wb(1'b0, 8'h40, 32'h0);
    check("sat_clear", rd[SAT_BIT], 1'b0);
    $display("test invert done");
    // Step response per cut-off code from a cleared history.
    for (int c = 0; c < 4; c++)
    begin
      wb(1'b1, 8'h38, 32'h0);
      send(24'h0, 24'h0);
      recv();
      wb(1'b1, 8'h38, 32'h0100 | (c << 5));
      send(24'h0, 24'h0);
      recv();
      check("hpf_dc", got, 48'h0);
      e1 = (longint'(24'h100000) * coef[c]) >>> 16;
      e2 = (e1 * coef[c]) >>> 16;
      send(24'h100000, 24'h100000);
      recv();
      check("hpf_step", near(got.left, e1) && near(got.right, e1), 1'b1);
      send(24'h100000, 24'h100000);
      recv();
      check("hpf_decay", near(got.left, e2) && near(got.right, e2), 1'b1);
    end
    $display("test filter done");
    // Fill the buffer with the sink stalled, then drain it slowly.
    wb(1'b1, 8'h38, 32'h0);
    stall <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH + 1; i++)
      send(sample_t'(i), sample_t'(i + 16));
    // One more pair is held offered while buffer and stage are full, then taken once it drains.
    fork
      send(sample_t'(FIFO_DEPTH + 1), sample_t'(FIFO_DEPTH + 17));
      begin
        repeat (20) @(negedge core_clk_i);
        check("full_refuse", ar, 1'b0);
        @(posedge core_clk_i);
        {stall, slow} <= 2'b01;
      end
    join
    for (int i = 0; i < FIFO_DEPTH + 2; i++)
    begin
      recv();
      check("drain_order", got, {sample_t'(i), sample_t'(i + 16)});
    end
    repeat (4) @(negedge core_clk_i);
    check("drained", sv, 1'b0);
    $display("test buffer done");
    finish_test();
  end
endmodule
`default_nettype wire
